// ---- logic/wcl_pkg.sv ----
// shared constants, types and helpers of the watchdog control and lock block
package wcl_pkg;

    // register index as printed; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

    // field positions
    localparam int LOCK_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam int REG_W = 8;
    localparam logic [REG_W-1:0] STATUS_RST = 8'h00;
    localparam logic [REG_W-1:0] CTRL_RST = 8'h00;

    // period codes: 0x1..0xb select 8 << (code-1) oscillator cycles
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_MAX = 4'hb;
    localparam logic [3:0] CODE_ONE = 4'h1;
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] BASE_CYC = 14'h0008;

    // crossings finish on the second oscillator edge
    localparam logic [1:0] SYNC_LAST = 2'h1;

    // unlock window: four instructions of up to four system cycles
    localparam int CCP_INSTR = 4;
    localparam int CYC_PER_INSTR = 4;
    localparam logic [4:0] CCP_WIN_CYC = 5'(CCP_INSTR * CYC_PER_INSTR);

    typedef enum logic [1:0]
    {
        WCL_OFF = 2'b00,
        WCL_OPEN = 2'b01,
        WCL_CLOSED = 2'b11
    } wcl_state_t;

    typedef struct packed
    {
        logic [3:0] window;
        logic [3:0] period;
    } wcl_ctrl_t;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } wcl_apb_req_t;

    typedef struct packed
    {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } wcl_apb_rsp_t;

    // reserved codes enable nothing
    function automatic logic wcl_code_ok(input logic [3:0] code);
        return (code != CODE_OFF) && (code <= CODE_MAX);
    endfunction

endpackage

// ---- logic/wcl_sync.sv ----
// two-stage synchroniser with rising-edge pulse for the oscillator tick
`timescale 1ns/1ps
module wcl_sync
    import wcl_pkg::*;
(
    input wire logic clock_i,  // system clock
    input wire logic rst_n_i,  // async reset, active low
    input wire logic async_i,  // level from outside the clock domain
    output logic rise_o        // one-cycle pulse per rising edge
);

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
    } wcl_sync_st_t;

    wcl_sync_st_t st_r;
    wcl_sync_st_t st_nxt;

    // first stage feeds the second stage only
    always_comb
    begin
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rise_o = st_r.s2 & ~st_r.s3;

endmodule

// ---- logic/wcl_tick_cnt.sv ----
// oscillator tick counter with a code-selected terminal count
`timescale 1ns/1ps
module wcl_tick_cnt
    import wcl_pkg::*;
(
    input wire logic clock_i,       // system clock
    input wire logic rst_n_i,       // async reset, active low
    input wire logic clear_i,       // restart the count
    input wire logic tick_i,        // one oscillator tick
    input wire logic [3:0] code_i,  // period code 0x1..0xb
    output logic hit_o              // last tick of the period
);

    typedef struct packed
    {
        logic [CNT_W-1:0] cnt;
    } wcl_cnt_st_t;

    wcl_cnt_st_t st_r;
    wcl_cnt_st_t st_nxt;
    logic [CNT_W-1:0] limit;

    assign limit = BASE_CYC << (code_i - CODE_ONE);
    assign hit_o = tick_i & wcl_code_ok(code_i) & (st_r.cnt == CNT_W'(limit - 1'b1));

    always_comb
    begin
        st_nxt = st_r;
        if (clear_i || hit_o)
        begin
            st_nxt.cnt = '0;
        end
        else if (tick_i)
        begin
            st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

// ---- logic/wcl_watchdog_ctrl.sv ----
// watchdog control, lock and sync-busy registers with the timeout engine
//
// Operation
// - upper nibble selects closed window, enables window mode
// - lower nibble 0x1..0xb enables watchdog, sets timeout
// - in window mode lower nibble is open window
// - lock set makes control nibbles read-only
// - writing one to status bit 7 locks control
// - lock set by software or at boot, cleared in debug
// - nonzero period after boot sets lock automatically
// - lock write needs key unlock first
// - control write raises sync busy during crossing
// - sync busy clears itself when crossing completes
// - sync busy unprotected and always readable
// - status at index 0x01, resets to zero
// - control reset value comes from fuse configuration
// - normal timeout without restart issues system reset
// - restart during closed window issues system reset
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module wcl_watchdog_ctrl
    import wcl_pkg::*;
(
    input wire logic clock_i,               // system clock, 50 MHz
    input wire logic rst_n_i,               // async reset, active low
    input wire wcl_apb_req_t apb_req_i,     // apb request
    output wcl_apb_rsp_t apb_rsp_o,         // apb response
    input wire logic wdt_osc_i,             // watchdog oscillator, async
    input wire logic wdr_i,                 // restart instruction pulse
    input wire logic ccp_unlock_i,          // unlock key written pulse
    input wire logic debug_halt_i,          // cpu halted by debugger
    input wire logic boot_done_i,           // boot code finished, level
    input wire logic [REG_W-1:0] fuse_cfg_i, // fuse control value
    output logic sys_reset_o                // system reset request pulse
);

    typedef struct packed
    {
        logic fuse_done;
        logic boot_seen;
        wcl_ctrl_t ctrl;
        wcl_ctrl_t shadow;
        wcl_ctrl_t live;
        logic lock;
        logic busy;
        logic [1:0] busy_ticks;
        logic [4:0] ccp_cnt;
        logic wdr_pend;
        logic [1:0] wdr_ticks;
        wcl_state_t st;
        wcl_apb_rsp_t rsp;
        logic sys_rst;
    } wcl_top_st_t;

    wcl_top_st_t st_r;
    wcl_top_st_t st_nxt;

    logic tick_rise;
    logic cnt_clr;
    logic cnt_tick;
    logic cnt_hit;
    logic [3:0] cnt_code;
    logic wdr_fire;
    logic ccp_open;
    logic apb_setup;
    logic apb_done;
    logic addr_hit;
    logic ctrl_wr;
    logic ctrl_acc;
    logic lock_wr;
    logic boot_edge;
    logic boot_lock;
    logic per_en;
    logic win_en;
    logic [REG_W-1:0] status_val;
    logic [DATA_W-1:0] rd_data;

    wcl_sync u_osc_sync
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (wdt_osc_i),
        .rise_o (tick_rise)
    );

    wcl_tick_cnt u_tick_cnt
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .clear_i (cnt_clr),
        .tick_i (cnt_tick),
        .code_i (cnt_code),
        .hit_o (cnt_hit)
    );

    // apb: pready answers one cycle into the access phase, write lands on the done edge
    assign apb_setup = apb_req_i.psel & apb_req_i.penable & ~st_r.rsp.pready;
    assign apb_done = apb_req_i.psel & apb_req_i.penable & st_r.rsp.pready;
    assign addr_hit = (apb_req_i.paddr == ADDR_CTRL) || (apb_req_i.paddr == ADDR_STATUS);
    assign ccp_open = (st_r.ccp_cnt != '0);
    assign ctrl_wr = apb_done & apb_req_i.pwrite & (apb_req_i.paddr == ADDR_CTRL);
    // writes while busy are not allowed; they are dropped rather than half-crossed
    assign ctrl_acc = ctrl_wr & ccp_open & ~st_r.lock & ~st_r.busy & st_r.fuse_done;
    assign lock_wr = apb_done & apb_req_i.pwrite & (apb_req_i.paddr == ADDR_STATUS)
                     & apb_req_i.pwdata[LOCK_BIT] & ccp_open;
    assign boot_edge = boot_done_i & ~st_r.boot_seen & st_r.fuse_done;
    assign boot_lock = boot_edge & (st_r.ctrl.period != CODE_OFF);
    assign per_en = wcl_code_ok(st_r.live.period);
    assign win_en = wcl_code_ok(st_r.live.window);
    assign cnt_code = (st_r.st == WCL_CLOSED) ? st_r.live.window : st_r.live.period;
    assign cnt_tick = tick_rise & (st_r.st != WCL_OFF) & ~debug_halt_i;

    always_comb
    begin
        status_val = STATUS_RST;
        status_val[LOCK_BIT] = st_r.lock;
        status_val[BUSY_BIT] = st_r.busy;
        rd_data = '0;
        if (apb_req_i.paddr == ADDR_CTRL)
        begin
            rd_data[REG_W-1:0] = st_r.ctrl;
        end
        else if (apb_req_i.paddr == ADDR_STATUS)
        begin
            rd_data[REG_W-1:0] = status_val;
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sys_rst = 1'b0;
        st_nxt.rsp.pready = 1'b0;
        st_nxt.rsp.pslverr = 1'b0;
        cnt_clr = 1'b0;
        wdr_fire = 1'b0;

        // fuse value is caught on the first edge after reset release
        if (!st_r.fuse_done)
        begin
            st_nxt.fuse_done = 1'b1;
            st_nxt.ctrl = fuse_cfg_i;
            st_nxt.shadow = fuse_cfg_i;
            st_nxt.live = fuse_cfg_i;
        end

        if (st_r.ccp_cnt != '0)
        begin
            st_nxt.ccp_cnt = 5'(st_r.ccp_cnt - 1'b1);
        end
        if (ccp_unlock_i)
        begin
            st_nxt.ccp_cnt = CCP_WIN_CYC;
        end

        if (apb_setup)
        begin
            st_nxt.rsp.pready = 1'b1;
            st_nxt.rsp.prdata = rd_data;
            st_nxt.rsp.pslverr = ~addr_hit;
        end

        // control crossing: new value reaches the oscillator side on its second edge
        if (st_r.busy && tick_rise)
        begin
            if (st_r.busy_ticks == SYNC_LAST)
            begin
                st_nxt.live = st_r.shadow;
                st_nxt.busy = 1'b0;
                st_nxt.busy_ticks = '0;
                cnt_clr = 1'b1;
            end
            else
            begin
                st_nxt.busy_ticks = 2'(st_r.busy_ticks + 1'b1);
            end
        end

        // restart crossing; a second restart while one is pending is ignored
        if (st_r.wdr_pend && tick_rise)
        begin
            if (st_r.wdr_ticks == SYNC_LAST)
            begin
                wdr_fire = 1'b1;
                st_nxt.wdr_pend = 1'b0;
                st_nxt.wdr_ticks = '0;
            end
            else
            begin
                st_nxt.wdr_ticks = 2'(st_r.wdr_ticks + 1'b1);
            end
        end
        if (wdr_i && !st_r.wdr_pend && !debug_halt_i && st_r.st != WCL_OFF)
        begin
            st_nxt.wdr_pend = 1'b1;
            st_nxt.wdr_ticks = '0;
        end

        if (debug_halt_i)
        begin
            st_nxt.lock = 1'b0;
        end

        if (ctrl_acc)
        begin
            st_nxt.ctrl = apb_req_i.pwdata[REG_W-1:0];
            st_nxt.shadow = apb_req_i.pwdata[REG_W-1:0];
            st_nxt.busy = 1'b1;
            st_nxt.busy_ticks = '0;
            st_nxt.ccp_cnt = '0;
        end
        if (lock_wr)
        begin
            st_nxt.lock = 1'b1;
            st_nxt.ccp_cnt = '0;
        end
        if (boot_edge)
        begin
            st_nxt.boot_seen = 1'b1;
        end
        if (boot_lock)
        begin
            st_nxt.lock = 1'b1;
        end

        if (debug_halt_i)
        begin
            // a halt resets the count; resuming starts with a normal period
            cnt_clr = 1'b1;
            st_nxt.wdr_pend = 1'b0;
            st_nxt.st = per_en ? WCL_OPEN : WCL_OFF;
        end
        else
        begin
            case (st_r.st)
                WCL_OFF:
                begin
                    if (per_en)
                    begin
                        st_nxt.st = WCL_OPEN;
                        cnt_clr = 1'b1;
                    end
                end
                WCL_OPEN:
                begin
                    if (!per_en)
                    begin
                        st_nxt.st = WCL_OFF;
                    end
                    else if (wdr_fire)
                    begin
                        cnt_clr = 1'b1;
                        st_nxt.st = win_en ? WCL_CLOSED : WCL_OPEN;
                    end
                    else if (cnt_hit)
                    begin
                        st_nxt.sys_rst = 1'b1;
                        cnt_clr = 1'b1;
                    end
                end
                WCL_CLOSED:
                begin
                    if (!per_en)
                    begin
                        st_nxt.st = WCL_OFF;
                    end
                    else if (wdr_fire)
                    begin
                        st_nxt.sys_rst = 1'b1;
                        cnt_clr = 1'b1;
                        st_nxt.st = WCL_OPEN;
                    end
                    else if (cnt_hit || !win_en)
                    begin
                        cnt_clr = 1'b1;
                        st_nxt.st = WCL_OPEN;
                    end
                end
                default:
                begin
                    st_nxt.st = WCL_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RST;
            st_r.st <= WCL_OFF;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign apb_rsp_o = st_r.rsp;
    assign sys_reset_o = st_r.sys_rst;

    property p_lock_holds_ctrl;
        @(posedge clock_i) disable iff (!rst_n_i)
        st_r.lock && st_r.fuse_done && ctrl_wr |=> st_r.ctrl == $past(st_r.ctrl);
    endproperty
    a_lock_holds_ctrl: assert property (p_lock_holds_ctrl)
        else $error("control changed while locked");

    property p_lock_falls_debug;
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(st_r.lock) |-> $past(debug_halt_i);
    endproperty
    a_lock_falls_debug: assert property (p_lock_falls_debug)
        else $error("lock cleared outside debug halt");

    property p_lock_rise_cause;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(st_r.lock) |-> $past(lock_wr || boot_lock) && $past(ccp_open || boot_lock);
    endproperty
    a_lock_rise_cause: assert property (p_lock_rise_cause)
        else $error("lock set without unlock or boot");

    property p_lock_write_sets;
        @(posedge clock_i) disable iff (!rst_n_i)
        lock_wr |=> st_r.lock;
    endproperty
    a_lock_write_sets: assert property (p_lock_write_sets)
        else $error("unlocked lock write did not set lock");

    property p_boot_lock;
        @(posedge clock_i) disable iff (!rst_n_i)
        boot_lock |=> st_r.lock && st_r.boot_seen;
    endproperty
    a_boot_lock: assert property (p_boot_lock)
        else $error("nonzero period at boot did not lock");

    property p_busy_set;
        @(posedge clock_i) disable iff (!rst_n_i)
        ctrl_acc |=> st_r.busy && st_r.ctrl == $past(apb_req_i.pwdata[REG_W-1:0]);
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("accepted control write did not raise busy");

    property p_busy_clear;
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(st_r.busy) |-> $past(tick_rise) && st_r.live == st_r.shadow;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy cleared without finished crossing");

    property p_status_read;
        @(posedge clock_i) disable iff (!rst_n_i)
        apb_setup && apb_req_i.paddr == ADDR_STATUS
        |=> apb_rsp_o.pready && apb_rsp_o.prdata[BUSY_BIT] == $past(st_r.busy);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not show busy");

    property p_fuse_load;
        @(posedge clock_i) disable iff (!rst_n_i)
        !st_r.fuse_done |=> st_r.ctrl == $past(fuse_cfg_i) && st_r.live == $past(fuse_cfg_i);
    endproperty
    a_fuse_load: assert property (p_fuse_load)
        else $error("control not loaded from fuse");

    property p_reset_cause;
        @(posedge clock_i) disable iff (!rst_n_i)
        sys_reset_o |-> $past(cnt_hit && st_r.st == WCL_OPEN)
                        || $past(wdr_fire && st_r.st == WCL_CLOSED);
    endproperty
    a_reset_cause: assert property (p_reset_cause)
        else $error("system reset without cause");

    property p_closed_restart;
        @(posedge clock_i) disable iff (!rst_n_i)
        !debug_halt_i && per_en && st_r.st == WCL_CLOSED && wdr_fire
        |=> sys_reset_o ##1 !sys_reset_o;
    endproperty
    a_closed_restart: assert property (p_closed_restart)
        else $error("restart in closed window did not reset");

    property p_closed_to_open;
        @(posedge clock_i) disable iff (!rst_n_i)
        !debug_halt_i && per_en && st_r.st == WCL_CLOSED && cnt_hit && !wdr_fire
        |=> st_r.st == WCL_OPEN && !sys_reset_o;
    endproperty
    a_closed_to_open: assert property (p_closed_to_open)
        else $error("closed window did not open");

    property p_reserved_off;
        @(posedge clock_i) disable iff (!rst_n_i)
        !debug_halt_i && !per_en |=> st_r.st == WCL_OFF && !sys_reset_o;
    endproperty
    a_reserved_off: assert property (p_reserved_off)
        else $error("disabled or reserved period still running");

    property p_pready_pulse;
        @(posedge clock_i) disable iff (!rst_n_i)
        apb_rsp_o.pready |=> !apb_rsp_o.pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("pready held longer than one cycle");

endmodule

// ---- verif/wcl_watchdog_ctrl_bench.sv ----
// self-checking bench for the watchdog control, lock and sync-busy block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module wcl_watchdog_ctrl_bench
    import wcl_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wdt_osc = 1'b0;
    logic watchdog_restart_instruction = 1'b0;
    logic key_unlock_protection = 1'b0;
    logic dbg = 1'b0;
    logic boot = 1'b0;
    logic [REG_W-1:0] fuse = 8'h00;
    wcl_apb_req_t req = '0;
    wcl_apb_rsp_t rsp;
    logic sys_rst;
    logic [DATA_W-1:0] q;
    logic e;
    int errors = 0;
    int samples_checked = 0;
    int k;
    int n;

    wcl_watchdog_ctrl wcl_watchdog_ctrl_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .wdt_osc_i(wdt_osc), .wdr_i(watchdog_restart_instruction),
        .ccp_unlock_i(key_unlock_protection), .debug_halt_i(dbg), .boot_done_i(boot), .fuse_cfg_i(fuse),
        .sys_reset_o(sys_rst));

    initial
    begin
        forever #10 clock_i = ~clock_i;
    end

    // oscillator period of 8 system cycles, phase offset from the system clock
    initial
    begin
        #7;
        forever #80 wdt_osc = ~wdt_osc;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task do_reset(input logic [REG_W-1:0] f);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        boot <= 1'b0;
        fuse <= f;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask

    // one apb transfer; pready, read data and error are all taken at the same rising edge
    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        int w;
        w = 0;
        @(posedge clock_i);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= {24'h000000, d};
        @(posedge clock_i);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clock_i);
            w++;
            if (w > 20)
            begin
                errors++;
                finish_test();
            end
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task pwr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clock_i);
        key_unlock_protection <= 1'b1;
        @(posedge clock_i);
        key_unlock_protection <= 1'b0;
        apb(1'b1, a, d);
    endtask

    task wait_idle;
        int w;
        w = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 8'h00);
            w++;
            if (w > 30)
            begin
                errors++;
                finish_test();
            end
        end while (q[BUSY_BIT] !== 1'b0);
    endtask

    // runs cyc cycles, pulsing restart every ev cycles (0 = never), counting resets
    task run(input int cyc, input int ev, output int c);
        c = 0;
        for (int i = 0; i < cyc; i++)
        begin
            @(posedge clock_i);
            watchdog_restart_instruction <= (ev != 0) && (i % ev == 0);
            @(negedge clock_i);
            if (sys_rst === 1'b1)
                c++;
        end
        @(posedge clock_i);
        watchdog_restart_instruction <= 1'b0;
    endtask

    task wait_pulse(output int c);
        c = 0;
        do
        begin
            @(negedge clock_i);
            c++;
            if (c > 3000)
            begin
                errors++;
                finish_test();
            end
        end while (sys_rst !== 1'b1);
    endtask

    task t_reset_vals;
        do_reset(8'hc0);
        apb(1'b0, ADDR_CTRL, 8'h00);
        `CHK("ctrl reset", 8'hc0, q[7:0])
        boot <= 1'b1;
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("status reset", 32'h0, q)
        apb(1'b0, 8'h08, 8'h00);
        `CHK("unmapped err", 1'b1, e)
        $display("test reset values done");
    endtask

    task t_protect_sync;
        apb(1'b1, ADDR_CTRL, 8'h0c);
        apb(1'b0, ADDR_CTRL, 8'h00);
        `CHK("ctrl no unlock", 8'hc0, q[7:0])
        pwr(ADDR_CTRL, 8'h0c);
        pwr(ADDR_CTRL, 8'h05);
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("busy set", 1'b1, q[BUSY_BIT])
        wait_idle();
        `CHK("busy clear", 1'b0, q[BUSY_BIT])
        apb(1'b0, ADDR_CTRL, 8'h00);
        `CHK("ctrl while busy", 8'h0c, q[7:0])
        $display("test protection and sync done");
    endtask

    task t_periods;
        for (int c = 1; c <= 3; c++)
        begin
            pwr(ADDR_CTRL, 8'(c));
            wait_idle();
            wait_pulse(n);
            wait_pulse(n);
            `CHK("timeout cycles", 64 << (c - 1), n)
        end
        run(2000, 150, k);
        `CHK("kept alive", 0, k)
        // the last restart acted shortly before, so 400 cycles hold exactly one 256-cycle period
        run(400, 0, k);
        `CHK("one timeout", 1, k)
        $display("test normal periods done");
    endtask

    task t_window;
        int k2;
        pwr(ADDR_CTRL, 8'h23);
        wait_idle();
        run(80, 40, k);
        run(60, 0, k2);
        `CHK("closed restart", 1, k + k2)
        run(200, 0, k);
        `CHK("open timeout", 1, k)
        run(150, 150, k2);
        `CHK("open restart", 0, k2)
        pwr(ADDR_CTRL, 8'h0c);
        wait_idle();
        run(1200, 0, k);
        `CHK("reserved off", 0, k)
        $display("test window and reserved done");
    endtask

    task t_lock;
        apb(1'b1, ADDR_STATUS, 8'h80);
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("lock no unlock", 8'h00, q[7:0])
        pwr(ADDR_STATUS, 8'h81);
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("lock set", 8'h80, q[7:0])
        pwr(ADDR_CTRL, 8'h01);
        apb(1'b0, ADDR_CTRL, 8'h00);
        `CHK("ctrl locked", 8'h0c, q[7:0])
        pwr(ADDR_STATUS, 8'h00);
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("lock kept", 8'h80, q[7:0])
        @(posedge clock_i);
        dbg <= 1'b1;
        repeat (4) @(posedge clock_i);
        dbg <= 1'b0;
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("lock debug clr", 8'h00, q[7:0])
        pwr(ADDR_CTRL, 8'h0b);
        apb(1'b0, ADDR_CTRL, 8'h00);
        `CHK("ctrl unlocked", 8'h0b, q[7:0])
        wait_idle();
        $display("test lock done");
    endtask

    task t_boot_lock;
        do_reset(8'h03);
        boot <= 1'b1;
        repeat (2) @(posedge clock_i);
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK("boot lock", 8'h80, q[7:0])
        apb(1'b0, ADDR_CTRL, 8'h00);
        `CHK("ctrl fuse", 8'h03, q[7:0])
        $display("test boot lock done");
    endtask

    initial
    begin
        t_reset_vals();
        t_protect_sync();
        t_periods();
        t_window();
        t_lock();
        t_boot_lock();
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clock_i);
        errors++;
        finish_test();
    end
endmodule
